//--- rtl/kspc_defines.vh
// constants for the knock processor serial configuration block
// included by kspc_top.v
`ifndef KSPC_DEFINES_VH
`define KSPC_DEFINES_VH

`define KSPC_WORD_BITS 8
`define KSPC_VAL6_BITS 6
`define KSPC_VAL5_BITS 5
`define KSPC_ADR2_KNOCK 2'b00
`define KSPC_ADR2_REF 2'b01
`define KSPC_ADR2_GAIN 2'b10
`define KSPC_ADR3_TC 3'b110
`define KSPC_ADR3_TEST 3'b111
// fields of the test/channel value
`define KSPC_TST_TA 4
`define KSPC_TST_TB 3
`define KSPC_TST_TC 2
`define KSPC_TST_CS 1
`define KSPC_TST_CA 0
// reset values of the settings
`define KSPC_RST_VAL6 6'h00
`define KSPC_RST_VAL5 5'h00
`define KSPC_RST_TEST 5'h10
// timing
`define KSPC_CLK_HZ 100000000
`define KSPC_SCF_HZ 200000
`define KSPC_SCF_DIV (`KSPC_CLK_HZ / `KSPC_SCF_HZ)
`define KSPC_INT_RST_US 20
`define KSPC_INT_RST_CYC ((`KSPC_INT_RST_US * `KSPC_CLK_HZ) / 1000000)

`endif

//--- rtl/kspc_sync.v
// two-flop synchroniser for pins arriving from outside the clk domain
// assumes a single free-running clk; synchronous active-high reset
`timescale 1ns/10ps
module kspc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk, // system clock
  input wire srst, // synchronous reset
  input wire [WIDTH-1:0] d, // asynchronous inputs
  output reg [WIDTH-1:0] q // synchronised outputs
);
  reg [WIDTH-1:0] meta_r;

  always @(posedge clk)
  begin
    if (srst)
    begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

//--- rtl/kspc_top.v
// serial programming front end and mode gating of the knock processor
// host drives sck/mosi/cs_n asynchronously; clk is much faster than sck
`timescale 1ns/10ps
`include "kspc_defines.vh"
module kspc_top (
  input wire clk, // system clock, 100 MHz
  input wire srst, // synchronous reset, active high
  input wire sck, // serial clock from host
  input wire mosi, // serial data from host
  input wire cs_n, // chip select, active low
  input wire int_hold, // high integrate, low hold
  input wire test_n, // low selects test mode
  output wire miso_o, // open-drain data out level, always 0
  output wire miso_oe, // high while pulling miso low
  output reg [5:0] knock_freq, // active knock filter step
  output reg [5:0] ref_freq, // active reference filter step
  output reg [5:0] atten_step, // active balance attenuation step
  output reg [4:0] int_tc, // active integrator time constant step
  output reg [5:0] knock_gain, // knock path gain step, 0 is unity
  output reg [5:0] ref_gain, // reference path gain step, 0 is unity
  output reg sensor_sel, // sensor channel feeding both filters
  output reg [2:0] test_src, // test mux source code ta,tb,tc
  output reg [2:0] out_src, // integrator_output source
  output reg in_amp_pd, // input amplifiers powered down
  output reg out_buf_pd, // output buffer powered down
  output reg integrating, // integrate mode active
  output reg integ_reset, // integrator reset pulse
  output reg scf_clk // switched-capacitor clock
);
  // out_src codes
  localparam [2:0] SRC_INTEG = 3'd0;
  localparam [2:0] SRC_KRECT = 3'd1;
  localparam [2:0] SRC_REF = 3'd2;
  localparam [2:0] SRC_KFILT = 3'd3;
  localparam [2:0] SRC_RFILT = 3'd4;
  localparam [2:0] SRC_AAF = 3'd5;
  // mode states
  localparam [1:0] ST_HOLD = 2'b01;
  localparam [1:0] ST_INTEG = 2'b10;
  localparam RST_CNT_W = 12;
  localparam integer RST_CYC_I = `KSPC_INT_RST_CYC;
  localparam integer SCF_HALF_I = (`KSPC_SCF_DIV) / 2;
  // cut on purpose: both counts fit their counters
  localparam [RST_CNT_W-1:0] RST_CYC = RST_CYC_I[RST_CNT_W-1:0];
  localparam [7:0] SCF_HALF = SCF_HALF_I[7:0];

  //////////////////////////////////////////////////////////////////////
  // pin synchronisation

  wire sck_s;
  wire mosi_s;
  wire cs_n_s;
  wire ih_s;
  wire test_n_s;

  kspc_sync #(
    .WIDTH(5),
    .RST_VAL(5'b1_1101)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .d({sck, cs_n, mosi, int_hold, test_n}),
    .q({sck_s, cs_n_s, mosi_s, ih_s, test_n_s})
  );

  // device only listens; miso never pulled low
  assign miso_o = 1'b0;
  assign miso_oe = 1'b0;

  //////////////////////////////////////////////////////////////////////
  // serial receiver

  reg sck_d_r;
  reg ih_d_r;
  reg [7:0] shift_r;
  reg [2:0] bit_cnt_r;
  reg word_done_r;
  reg [7:0] word_r;

  wire sck_rise = sck_s & ~sck_d_r;

  always @(posedge clk)
  begin
    if (srst)
    begin
      sck_d_r <= 1'b1;
      shift_r <= 8'h00;
      bit_cnt_r <= 3'd0;
      word_done_r <= 1'b0;
      word_r <= 8'h00;
    end
    else
    begin
      sck_d_r <= sck_s;
      word_done_r <= 1'b0;
      if (cs_n_s)
      begin
        bit_cnt_r <= 3'd0;
      end
      else if (sck_rise)
      begin
        shift_r <= {shift_r[6:0], mosi_s};
        bit_cnt_r <= bit_cnt_r + 3'd1;
        if (bit_cnt_r == 3'd7)
        begin
          word_r <= {shift_r[6:0], mosi_s};
          word_done_r <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pending copies and mode

  reg [5:0] knock_p_r;
  reg [5:0] ref_p_r;
  reg [5:0] gain_p_r;
  reg [4:0] tc_p_r;
  reg [4:0] test_p_r;
  reg [4:0] test_a_r;
  reg [1:0] mode_r;
  reg [RST_CNT_W-1:0] rst_cnt_r;

  wire ih_rise = ih_s & ~ih_d_r;
  wire hold_entry = ~ih_s & ih_d_r;
  wire load_now = (mode_r == ST_HOLD) & ~ih_s;

  always @(posedge clk)
  begin
    if (srst)
    begin
      knock_p_r <= `KSPC_RST_VAL6;
      ref_p_r <= `KSPC_RST_VAL6;
      gain_p_r <= `KSPC_RST_VAL6;
      tc_p_r <= `KSPC_RST_VAL5;
      test_p_r <= `KSPC_RST_TEST;
    end
    else if (word_done_r)
    begin
      if (word_r[7:6] == `KSPC_ADR2_KNOCK)
        knock_p_r <= word_r[5:0];
      else if (word_r[7:6] == `KSPC_ADR2_REF)
        ref_p_r <= word_r[5:0];
      else if (word_r[7:6] == `KSPC_ADR2_GAIN)
        gain_p_r <= word_r[5:0];
      else if (word_r[7:5] == `KSPC_ADR3_TC)
        tc_p_r <= word_r[4:0];
      else
        test_p_r <= word_r[4:0];
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      ih_d_r <= 1'b0;
      mode_r <= ST_HOLD;
      rst_cnt_r <= {RST_CNT_W{1'b0}};
      integ_reset <= 1'b0;
      integrating <= 1'b0;
      knock_freq <= `KSPC_RST_VAL6;
      ref_freq <= `KSPC_RST_VAL6;
      atten_step <= `KSPC_RST_VAL6;
      int_tc <= `KSPC_RST_VAL5;
      test_a_r <= `KSPC_RST_TEST;
    end
    else
    begin
      ih_d_r <= ih_s;
      integrating <= ih_s;
      case (mode_r)
        ST_HOLD:
          if (ih_s)
            mode_r <= ST_INTEG;
        ST_INTEG:
          if (~ih_s)
            mode_r <= ST_HOLD;
        default:
          mode_r <= ST_HOLD;
      endcase
      // integrator reset for the settle time after integrate starts
      if (ih_rise)
      begin
        rst_cnt_r <= RST_CYC;
        integ_reset <= 1'b1;
      end
      else if (rst_cnt_r > 1)
        rst_cnt_r <= rst_cnt_r - 1'b1;
      else
      begin
        rst_cnt_r <= {RST_CNT_W{1'b0}};
        integ_reset <= 1'b0;
      end
      // one cycle after the pending write so the new word is visible
      if (hold_entry | load_now)
      begin
        knock_freq <= knock_p_r;
        ref_freq <= ref_p_r;
        atten_step <= gain_p_r;
        int_tc <= tc_p_r;
        test_a_r <= test_p_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // balance, channel and test routing

  reg [2:0] src_nxt;

  always @*
  begin
    src_nxt = SRC_INTEG;
    if (~test_n_s)
    begin
      case ({test_a_r[`KSPC_TST_TB], test_a_r[`KSPC_TST_TC]})
        2'b00: src_nxt = test_a_r[`KSPC_TST_CS] ? SRC_REF : SRC_KRECT;
        2'b01: src_nxt = test_a_r[`KSPC_TST_CS] ? SRC_RFILT : SRC_KFILT;
        2'b10: src_nxt = SRC_AAF;
        default: src_nxt = SRC_INTEG;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      knock_gain <= 6'h00;
      ref_gain <= 6'h00;
      sensor_sel <= 1'b0;
      test_src <= 3'b000;
      out_src <= SRC_INTEG;
      in_amp_pd <= 1'b0;
      out_buf_pd <= 1'b0;
    end
    else
    begin
      knock_gain <= test_a_r[`KSPC_TST_CA] ? 6'h00 : atten_step;
      ref_gain <= test_a_r[`KSPC_TST_CA] ? atten_step : 6'h00;
      sensor_sel <= test_a_r[`KSPC_TST_CS];
      test_src <= test_a_r[4:2];
      out_src <= src_nxt;
      in_amp_pd <= ~test_n_s & ~test_a_r[`KSPC_TST_TA];
      out_buf_pd <= (src_nxt == SRC_AAF);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // switched-capacitor sampling clock

  reg [7:0] scf_cnt_r;

  always @(posedge clk)
  begin
    if (srst)
    begin
      scf_cnt_r <= 8'h00;
      scf_clk <= 1'b0;
    end
    else if (scf_cnt_r == SCF_HALF - 8'd1)
    begin
      scf_cnt_r <= 8'h00;
      scf_clk <= ~scf_clk;
    end
    else
      scf_cnt_r <= scf_cnt_r + 8'd1;
  end
endmodule

//--- tb/kspc_host.sv
// serial master model standing in for the engine management processor
// assumes the bench clk; all pins change just after a clk rising edge
`timescale 1ns/10ps
module kspc_host (
  input wire clk, // bench clock
  output logic sck, // serial clock, idle high
  output logic mosi, // serial data
  output logic cs_n // select, active low
);
  initial
  begin
    sck = 1'b1;
    mosi = 1'b0;
    cs_n = 1'b1;
  end
  ////////////////////////////////////////
  // 80 ns phases; sck stands high between frames
  task send(input logic [7:0] w, input int n);
    int i;
    begin
      @(posedge clk);
      cs_n <= 1'b0;
      for (i = 7; i > 7 - n; i--)
      begin
        repeat (8) @(posedge clk);
        sck <= 1'b0;
        mosi <= w[i];
        repeat (8) @(posedge clk);
        sck <= 1'b1;
      end
      repeat (8) @(posedge clk);
      cs_n <= 1'b1;
      // undriven line: show a changed level rather than the old bit
      mosi <= ~mosi;
    end
  endtask
  // sck pulses with select high; the device must ignore them
  task stray(input int n);
    int k;
    begin
      for (k = 0; k < n; k++)
      begin
        repeat (8) @(posedge clk);
        sck <= 1'b0;
        mosi <= ~mosi;
        repeat (8) @(posedge clk);
        sck <= 1'b1;
      end
    end
  endtask
endmodule

//--- tb/kspc_checker.sv
// concurrent checks on the ports of kspc_top
// bound to kspc_top; one clk domain with synchronous srst
`timescale 1ns/10ps
module kspc_checker (
  input wire clk, // clock
  input wire srst, // reset
  input wire cs_n, // select
  input wire int_hold, // mode pin
  input wire [5:0] knock_freq, // knock step
  input wire [5:0] ref_freq, // ref step
  input wire [5:0] atten_step, // balance step
  input wire [4:0] int_tc, // time constant
  input wire [5:0] knock_gain, // knock gain
  input wire [5:0] ref_gain, // ref gain
  input wire [2:0] out_src, // test source
  input wire out_buf_pd, // buffer off
  input wire integrating, // mode
  input wire integ_reset, // reset pulse
  input wire scf_clk // filter clock
);
  reg [11:0] rcnt_r;
  reg [8:0] scnt_r;
  reg scf_r;
  reg seen_r;
  wire [22:0] cfg = {knock_freq, ref_freq, atten_step, int_tc};
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // first scf half period after reset has free length, so it is skipped
  always @(posedge clk)
  begin
    scf_r <= scf_clk;
    seen_r <= !srst && (seen_r || scf_clk != scf_r);
    rcnt_r <= (srst || !integ_reset) ? 12'h000 : rcnt_r + 12'h001;
    scnt_r <= (srst || scf_clk != scf_r) ? 9'h000 : scnt_r + 9'h001;
  end
  property p_freeze; integrating && $past(integrating, 3) |-> $stable(cfg); endproperty
  a_freeze: assert property (p_freeze) else $error("setting moved in integrate");
  property p_idle; (cs_n && !integrating) [*8] |=> $stable(cfg); endproperty
  a_idle: assert property (p_idle) else $error("setting moved while deselected");
  property p_gain; $stable(atten_step) [*3] |-> (knock_gain | ref_gain) == atten_step
    && (knock_gain == 6'h00 || ref_gain == 6'h00); endproperty
  a_gain: assert property (p_gain) else $error("balance gains wrong");
  property p_buf; $stable(out_src) [*2] |-> out_buf_pd == (out_src == 3'h5); endproperty
  a_buf: assert property (p_buf) else $error("output buffer state wrong");
  property p_rise; $rose(integrating) |-> ##[0:3] integ_reset; endproperty
  a_rise: assert property (p_rise) else $error("no integrator reset");
  property p_len; $fell(integ_reset) |-> rcnt_r == 12'h7d0; endproperty
  a_len: assert property (p_len) else $error("integrator reset length wrong");
  property p_scf; seen_r && scf_clk != scf_r |-> scnt_r == 9'h0f9; endproperty
  a_scf: assert property (p_scf) else $error("filter clock half period wrong");
  property p_mode; $stable(int_hold) [*4] |-> integrating == int_hold; endproperty
  a_mode: assert property (p_mode) else $error("mode does not follow pin");
  c_integ: cover property ($rose(integ_reset));
  c_buf: cover property (out_buf_pd);
  c_hold: cover property ($fell(integrating));
endmodule

bind kspc_top kspc_checker u_chk (.clk, .srst, .cs_n, .int_hold, .knock_freq, .ref_freq,
  .atten_step, .int_tc, .knock_gain, .ref_gain, .out_src, .out_buf_pd, .integrating,
  .integ_reset, .scf_clk);

//--- tb/kspc_top_tb_top.sv
// self-checking bench: kspc_top against an integer model of its settings
// kspc_host plays the serial master; kspc_checker binds itself to the dut
`timescale 1ns/10ps
module kspc_top_tb_top;
  logic clk, srst, int_hold, test_n;
  logic [7:0] w;
  logic [7:0] q[$];
  wire sck, mosi, cs_n, sensor_sel, in_amp_pd, out_buf_pd, integrating, integ_reset;
  wire [5:0] knock_freq, ref_freq, atten_step, knock_gain, ref_gain;
  wire [4:0] int_tc;
  wire [2:0] test_src, out_src;
  integer error_cnt = 0, total_checks = 0, i, eo;
  integer kf = 0, rf = 0, at = 0, tc = 0, tw = 5'h10;
  kspc_top dut (.clk, .srst, .sck, .mosi, .cs_n, .int_hold, .test_n, .miso_o(), .miso_oe(),
    .knock_freq, .ref_freq, .atten_step, .int_tc, .knock_gain, .ref_gain, .sensor_sel,
    .test_src, .out_src, .in_amp_pd, .out_buf_pd, .integrating, .integ_reset, .scf_clk());
  kspc_host host (.clk, .sck, .mosi, .cs_n);
  ////////////////////////////////////////
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task cmp(input string n, input integer e, input logic [7:0] g);
    begin
      total_checks++;
      if (g !== 8'(e))
      begin
        error_cnt++;
        $display("ERROR %s expected %0h seen %0h", n, e, g);
      end
    end
  endtask
  task chk;
    begin
      eo = test_n ? 0 : tw[3] ? (tw[2] ? 0 : 5) : 1 + tw[2:1];
      cmp("knock_freq", kf, knock_freq);
      cmp("ref_freq", rf, ref_freq);
      cmp("atten_step", at, atten_step);
      cmp("int_tc", tc, int_tc);
      cmp("knock_gain", tw[0] ? 0 : at, knock_gain);
      cmp("ref_gain", tw[0] ? at : 0, ref_gain);
      cmp("sensor_sel", tw[1], sensor_sel);
      cmp("test_src", tw[4:2], test_src);
      cmp("out_src", eo, out_src);
      cmp("in_amp_pd", !test_n && !tw[4], in_amp_pd);
      cmp("out_buf_pd", eo == 5, out_buf_pd);
    end
  endtask
  task apply(input logic [7:0] v);
    begin
      if (v[7:6] == 2'h0) kf = v[5:0];
      else if (v[7:6] == 2'h1) rf = v[5:0];
      else if (v[7:6] == 2'h2) at = v[5:0];
      else if (v[5]) tw = v[4:0];
      else tc = v[4:0];
    end
  endtask
  // words sent in integrate wait in the queue until hold entry
  task word(input logic [7:0] v);
    begin
      host.send(v, 8);
      repeat (10) @(posedge clk);
      if (int_hold) q.push_back(v);
      else apply(v);
      chk;
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    srst = 1;
    int_hold = 0;
    test_n = 1;
    w = 0;
    void'($urandom(32'h0000_eed0));
    repeat (2) @(posedge clk);
    srst <= 0;
    repeat (3) @(posedge clk);
    chk;
    $display("test reset done");
    for (i = 0; i < 32; i++)
    begin
      test_n <= 0;
      word({3'h7, 5'(i)});
    end
    $display("test test_word done");
    for (i = 0; i < 25; i++)
    begin
      w = 8'($urandom);
      if (i % 5 < 3) w[7:6] = 2'(i % 5);
      else w[7:5] = 3'(i % 5 + 3);
      test_n <= 1'($urandom);
      word(w);
    end
    $display("test random done");
    host.stray(8);
    repeat (10) @(posedge clk);
    chk;
    host.send(8'h3f, 5);
    repeat (10) @(posedge clk);
    chk;
    word(8'h15);
    $display("test partial done");
    int_hold <= 1;
    repeat (10) @(posedge clk);
    cmp("integrating", 1, integrating);
    cmp("integ_reset", 1, integ_reset);
    word(8'h47);
    word(8'hcb);
    repeat (2000) @(posedge clk);
    cmp("integ_reset", 0, integ_reset);
    int_hold <= 0;
    repeat (10) @(posedge clk);
    while (q.size() > 0)
      apply(q.pop_front());
    chk;
    cmp("integrating", 0, integrating);
    $display("test integrate done");
    stop_test;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
endmodule
